/* File: src/adc_control_top.sv */
/*
 * converter control block: control register, conversion start and abort,
 * successive-approximation sequencer, result registers, threshold flag and
 * interrupt, all behind an AHB-Lite slave.
 * assumes one bus master, whole-word single transfers, and an external
 * comparator that reports whether the input is above the trial code.
 */
// The implementer's own choices: register access over AHB-Lite and the register offsets.
// Overview of operation
// - continuous mode re-arms go after each conversion, except when stop-on-threshold is set and the threshold flag is set
// - single mode clears go after conversion
// - clock select picks rc oscillator or divided clock
// - format bit chooses right or left justification
// - writing go with on set starts; go reads one while busy
// - clearing go aborts, keeps partial, returns idle
// - aborted conversion sets no flags, skips threshold
// - bits five, three, one read zero
`timescale 1ns/1ps
module adc_control_top (
	input  wire logic        I_CLK,
	input  wire logic        I_NRST,
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	output logic             O_IRQ,
	input  wire logic        I_RC_OSC,
	input  wire logic        I_CMP_ABOVE,
	output logic      [11:0] O_DAC_CODE,
	output logic             O_SAMPLE,
	output logic             O_BUSY
);

	localparam int RW = adc_ctrl_pkg::RES_W;
	localparam int IW = adc_ctrl_pkg::IDX_W;
	localparam int SW = adc_ctrl_pkg::STAT_W;

	adc_ctrl_pkg::conv_state_e state_r;

	logic          on_r;
	logic          continuous_enable_r;
	logic          cs_r;
	logic          fm_r;
	logic          go_r;
	logic [7:0]    clkdiv_r;
	logic          soi_r;
	logic [RW-1:0] thresh_r;
	logic [RW-1:0] result_r;
	logic [RW-1:0] prev_r;
	logic [SW-1:0] stat_r;
	logic [SW-1:0] stat_nxt;
	logic [SW-1:0] mask_r;
	logic [RW-1:0] decided_r;
	logic [IW-1:0] idx_r;
	logic          cmp_meta_r;
	logic          cmp_sync_r;
	logic          wr_pend_r;
	logic [7:0]    wr_addr_r;
	logic [31:0]   rd_mux;
	logic [7:0]    ctrl_rd;
	logic          rd_acc;
	logic          addr_acc;
	logic          ctrl_wr;
	logic [7:0]    wd;
	logic          tick;
	logic          start;
	logic          abort;
	logic          complete;
	logic          thr_hit;
	logic          retrig;
	logic [RW-1:0] decided_nxt;
	logic [RW-1:0] trial_nxt;

	////////////////////////////////////////////////////////////////////////
	// bus slave

	assign addr_acc = I_HSEL & I_HTRANS[1] & I_HREADY;
	assign rd_acc   = addr_acc & ~I_HWRITE;
	assign wd       = I_HWDATA[7:0];
	assign ctrl_wr  = wr_pend_r && (wr_addr_r == adc_ctrl_pkg::OFF_CTRL);

	// unimplemented control bits are simply never placed
	assign ctrl_rd = {on_r, continuous_enable_r, 1'b0, cs_r, 1'b0, fm_r, 1'b0, go_r};

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (I_HADDR[7:0])
			adc_ctrl_pkg::OFF_CTRL:   rd_mux = {24'h00_0000, ctrl_rd};
			adc_ctrl_pkg::OFF_CLKDIV: rd_mux = {24'h00_0000, clkdiv_r};
			adc_ctrl_pkg::OFF_RESULT: rd_mux = fm_r ? {20'h0_0000, result_r}
				: {16'h0000, result_r, 4'h0};
			adc_ctrl_pkg::OFF_PREV:   rd_mux = fm_r ? {20'h0_0000, prev_r}
				: {16'h0000, prev_r, 4'h0};
			adc_ctrl_pkg::OFF_CONFIG: rd_mux = {31'h0000_0000, soi_r};
			adc_ctrl_pkg::OFF_THRESH: rd_mux = {20'h0_0000, thresh_r};
			adc_ctrl_pkg::OFF_STATUS: rd_mux = {30'h0000_0000, stat_r};
			adc_ctrl_pkg::OFF_MASK:   rd_mux = {30'h0000_0000, mask_r};
			default:                  rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= 8'h00;
			O_HRDATA    <= 32'h0000_0000;
			O_HREADYOUT <= 1'b1;
			O_HRESP     <= 1'b0;
		end else begin
			wr_pend_r   <= addr_acc & I_HWRITE & (I_HADDR[31:8] == 24'h00_0000);
			wr_addr_r   <= I_HADDR[7:0];
			O_HRDATA    <= (rd_acc && I_HADDR[31:8] == 24'h00_0000) ? rd_mux
				: 32'h0000_0000;
			O_HREADYOUT <= 1'b1;
			O_HRESP     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			on_r   <= adc_ctrl_pkg::CTRL_RST[adc_ctrl_pkg::ON_BIT];
			continuous_enable_r <= adc_ctrl_pkg::CTRL_RST[adc_ctrl_pkg::CONTINUOUS_ENABLE_BIT];
			cs_r   <= adc_ctrl_pkg::CTRL_RST[adc_ctrl_pkg::CS_BIT];
			fm_r   <= adc_ctrl_pkg::CTRL_RST[adc_ctrl_pkg::FM_BIT];
		end else if (ctrl_wr) begin
			on_r   <= wd[adc_ctrl_pkg::ON_BIT];
			continuous_enable_r <= wd[adc_ctrl_pkg::CONTINUOUS_ENABLE_BIT];
			cs_r   <= wd[adc_ctrl_pkg::CS_BIT];
			fm_r   <= wd[adc_ctrl_pkg::FM_BIT];
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			clkdiv_r <= adc_ctrl_pkg::CLKDIV_RST;
			soi_r    <= 1'b0;
			thresh_r <= adc_ctrl_pkg::THRESH_RST;
			mask_r   <= adc_ctrl_pkg::MASK_RST;
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				adc_ctrl_pkg::OFF_CLKDIV: clkdiv_r <= wd;
				adc_ctrl_pkg::OFF_CONFIG: soi_r    <= wd[adc_ctrl_pkg::SOI_BIT];
				adc_ctrl_pkg::OFF_THRESH: thresh_r <= I_HWDATA[RW-1:0];
				adc_ctrl_pkg::OFF_MASK:   mask_r   <= I_HWDATA[SW-1:0];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion control

	assign start    = (state_r == adc_ctrl_pkg::ST_IDLE) && go_r && on_r && !ctrl_wr;
	assign abort    = ctrl_wr && (state_r != adc_ctrl_pkg::ST_IDLE)
		&& !(wd[adc_ctrl_pkg::ON_BIT] && wd[adc_ctrl_pkg::GO_BIT]);
	assign complete = (state_r == adc_ctrl_pkg::ST_CONV) && tick
		&& (idx_r == 4'h0) && !abort;
	assign thr_hit  = complete && (decided_nxt >= thresh_r);
	assign retrig   = continuous_enable_r && !(soi_r
		&& (stat_r[adc_ctrl_pkg::THR_BIT] || thr_hit));

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			go_r <= adc_ctrl_pkg::CTRL_RST[adc_ctrl_pkg::GO_BIT];
		end else if (ctrl_wr) begin
			if (!wd[adc_ctrl_pkg::ON_BIT]) begin
				go_r <= 1'b0;
			end else if (state_r == adc_ctrl_pkg::ST_IDLE) begin
				go_r <= wd[adc_ctrl_pkg::GO_BIT];
			end else begin
				go_r <= wd[adc_ctrl_pkg::GO_BIT] & (!complete | retrig);
			end
		end else if (complete) begin
			go_r <= retrig;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state_r <= adc_ctrl_pkg::ST_IDLE;
		end else begin
			case (state_r)
				adc_ctrl_pkg::ST_IDLE: begin
					if (start) begin
						state_r <= adc_ctrl_pkg::ST_ACQ;
					end
				end
				adc_ctrl_pkg::ST_ACQ: begin
					if (abort) begin
						state_r <= adc_ctrl_pkg::ST_IDLE;
					end else if (tick) begin
						state_r <= adc_ctrl_pkg::ST_CONV;
					end
				end
				adc_ctrl_pkg::ST_CONV: begin
					if (abort || complete) begin
						state_r <= adc_ctrl_pkg::ST_IDLE;
					end
				end
				default: state_r <= adc_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	conv_clock_gen u_clk_gen (
		.i_clk    (I_CLK),
		.i_nrst   (I_NRST),
		.i_sel_rc (cs_r),
		.i_div    (clkdiv_r),
		.i_run    (state_r != adc_ctrl_pkg::ST_IDLE),
		.i_rc_osc (I_RC_OSC),
		.o_tick   (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// successive approximation

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
		end else begin
			cmp_meta_r <= I_CMP_ABOVE;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	// current trial bit resolved by the comparator, next bit offered
	always_comb begin
		decided_nxt = decided_r | (RW'(cmp_sync_r) << idx_r);
		trial_nxt   = (idx_r == 4'h0) ? {RW{1'b0}} : (RW'(1) << (idx_r - 4'h1));
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			decided_r  <= {RW{1'b0}};
			idx_r      <= 4'h0;
			O_DAC_CODE <= 12'h000;
			O_SAMPLE   <= 1'b0;
			O_BUSY     <= 1'b0;
		end else begin
			O_SAMPLE <= (state_r == adc_ctrl_pkg::ST_ACQ) && !abort && !tick;
			O_BUSY   <= (state_r != adc_ctrl_pkg::ST_IDLE) && !abort && !complete;
			if (abort || complete) begin
				O_DAC_CODE <= 12'h000;
			end else if (state_r == adc_ctrl_pkg::ST_ACQ && tick) begin
				decided_r  <= {RW{1'b0}};
				idx_r      <= 4'(RW - 1);
				O_DAC_CODE <= 12'h800;
			end else if (state_r == adc_ctrl_pkg::ST_CONV && tick) begin
				decided_r  <= decided_nxt;
				idx_r      <= idx_r - 4'h1;
				O_DAC_CODE <= decided_nxt | trial_nxt;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			result_r <= {RW{1'b0}};
			prev_r   <= {RW{1'b0}};
		end else if (abort) begin
			// only bits already resolved survive an abort
			result_r <= (state_r == adc_ctrl_pkg::ST_CONV) ? decided_r : {RW{1'b0}};
		end else if (complete) begin
			prev_r   <= result_r;
			result_r <= decided_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flags and interrupt

	always_comb begin
		stat_nxt = stat_r;
		if (wr_pend_r && wr_addr_r == adc_ctrl_pkg::OFF_STATUS) begin
			stat_nxt = stat_r & ~I_HWDATA[SW-1:0];
		end
		// hardware set wins over a same-cycle clear
		if (complete) begin
			stat_nxt[adc_ctrl_pkg::DONE_BIT] = 1'b1;
		end
		if (thr_hit) begin
			stat_nxt[adc_ctrl_pkg::THR_BIT] = 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			stat_r <= adc_ctrl_pkg::STAT_RST;
			O_IRQ  <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			O_IRQ  <= |(stat_nxt & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	AST_UNIMPL_ZERO: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(rd_acc && I_HADDR == 32'h0000_0000)
		|=> (O_HRDATA[5] == 1'b0 && O_HRDATA[3] == 1'b0 && O_HRDATA[1] == 1'b0))
		else $error("unimplemented control bit read as one");

	AST_FORMAT: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(rd_acc && I_HADDR == 32'h0000_0008)
		|=> O_HRDATA == ($past(fm_r) ? {20'h0_0000, $past(result_r)}
			: {16'h0000, $past(result_r), 4'h0}))
		else $error("result justification wrong");

	AST_OFF_NO_GO: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		!on_r |-> (!go_r && state_r != adc_ctrl_pkg::ST_ACQ
			&& $past(state_r) != adc_ctrl_pkg::ST_CONV || state_r == adc_ctrl_pkg::ST_IDLE))
		else $error("conversion running while converter off");

	AST_START: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(state_r == adc_ctrl_pkg::ST_IDLE && go_r && on_r && !ctrl_wr)
		|=> state_r == adc_ctrl_pkg::ST_ACQ && go_r)
		else $error("go set but conversion did not start");

	AST_GO_BUSY: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		state_r != adc_ctrl_pkg::ST_IDLE |-> go_r)
		else $error("go reads zero during conversion");

	AST_SINGLE_CLEAR: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(complete && !continuous_enable_r && !ctrl_wr) |=> !go_r && state_r == adc_ctrl_pkg::ST_IDLE)
		else $error("go not cleared after single conversion");

	AST_CONTINUOUS_ENABLE_RETRIG: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(complete && continuous_enable_r && !soi_r && !ctrl_wr)
		|=> go_r ##1 state_r == adc_ctrl_pkg::ST_ACQ)
		else $error("continuous mode did not retrigger");

	AST_SOI_STOP: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(complete && continuous_enable_r && soi_r && thr_hit && !ctrl_wr) |=> !go_r)
		else $error("stop on threshold did not stop");

	AST_ABORT: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		(abort && state_r == adc_ctrl_pkg::ST_CONV)
		|=> state_r == adc_ctrl_pkg::ST_IDLE && !go_r && result_r == $past(decided_r))
		else $error("abort did not keep partial result");

	AST_ABORT_NOFLAG: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		abort |=> stat_r == ($past(stat_r) & ~($past(wr_addr_r) == adc_ctrl_pkg::OFF_STATUS
			? $past(I_HWDATA[SW-1:0]) : 2'h0)))
		else $error("aborted conversion raised a flag");

endmodule

/* File: src/adc_ctrl_pkg.sv */
/*
 * constants shared by the converter control block: register offsets,
 * control field positions, reset values, timing and state encoding.
 * assumes a 32-bit AHB-Lite register bus and a 12-bit successive-approximation core.
 */
package adc_ctrl_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_CLKDIV  = 8'h04;
	localparam logic [7:0] OFF_RESULT  = 8'h08;
	localparam logic [7:0] OFF_PREV    = 8'h0c;
	localparam logic [7:0] OFF_CONFIG  = 8'h10;
	localparam logic [7:0] OFF_THRESH  = 8'h14;
	localparam logic [7:0] OFF_STATUS  = 8'h18;
	localparam logic [7:0] OFF_MASK    = 8'h1c;

	// control register fields
	localparam int ON_BIT   = 7;
	localparam int CONTINUOUS_ENABLE_BIT = 6;
	localparam int CS_BIT   = 4;
	localparam int FM_BIT   = 2;
	localparam int GO_BIT   = 0;

	// config, status and mask fields
	localparam int SOI_BIT  = 0;
	localparam int DONE_BIT = 0;
	localparam int THR_BIT  = 1;

	// widths
	localparam int RES_W  = 12;
	localparam int IDX_W  = 4;
	localparam int STAT_W = 2;

	// reset values
	localparam logic [7:0]        CTRL_RST   = 8'h00;
	localparam logic [7:0]        CLKDIV_RST = 8'h00;
	localparam logic [RES_W-1:0]  THRESH_RST = 12'hfff;
	localparam logic [STAT_W-1:0] STAT_RST   = 2'h0;
	localparam logic [STAT_W-1:0] MASK_RST   = 2'h0;

	// conversion clock: system clock period is clock_divider_reg plus this base
	localparam logic [8:0] DIV_BASE = 9'h004;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ  = 2'b01,
		ST_CONV = 2'b10
	} conv_state_e;

endpackage

/* File: src/conv_clock_gen.sv */
/*
 * conversion clock enable: one-cycle tick from either the divided system
 * clock or the rising edge of the dedicated rc oscillator pin.
 * assumes the rc oscillator is much slower than the system clock.
 */
`timescale 1ns/1ps
module conv_clock_gen (
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_sel_rc,
	input  wire logic [7:0] i_div,
	input  wire logic       i_run,
	input  wire logic       i_rc_osc,
	output logic            o_tick
);

	logic       rc_meta_r;
	logic       rc_sync_r;
	logic       rc_prev_r;
	logic [8:0] cnt_r;
	logic [8:0] limit;
	logic       rc_rise;

	assign limit   = {1'b0, i_div} + adc_ctrl_pkg::DIV_BASE - 9'h001;
	assign rc_rise = rc_sync_r & ~rc_prev_r;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rc_meta_r <= 1'b0;
			rc_sync_r <= 1'b0;
			rc_prev_r <= 1'b0;
		end else begin
			rc_meta_r <= i_rc_osc;
			rc_sync_r <= rc_meta_r;
			rc_prev_r <= rc_sync_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_r  <= 9'h000;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			cnt_r  <= 9'h000;
			o_tick <= 1'b0;
		end else if (i_sel_rc) begin
			cnt_r  <= 9'h000;
			o_tick <= rc_rise;
		end else if (cnt_r >= limit) begin
			cnt_r  <= 9'h000;
			o_tick <= 1'b1;
		end else begin
			cnt_r  <= cnt_r + 9'h001;
			o_tick <= 1'b0;
		end
	end

	AST_DIV_TICK: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_run && !i_sel_rc && cnt_r == limit) ##1 i_run |-> o_tick)
		else $error("divided clock tick missing");

	AST_RC_TICK: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_run && i_sel_rc && !rc_rise) ##1 (i_run && i_sel_rc) |-> !o_tick)
		else $error("rc tick without oscillator edge");

endmodule

/* File: verification/adc_control_register_zero_tb.sv */
/*
 * self-checking bench for the converter control block: register table,
 * single, continuous, aborted and rc-clocked conversions, interrupt.
 * assumes adc_control_top with hreadyout fed back to hready.
 */
`timescale 1ns/1ps
module adc_control_register_zero_tb;

typedef struct packed {
	logic        wr;
	logic [31:0] addr;
	logic [31:0] data;
	logic [31:0] expv;
} row_s;

logic        clk;
logic        nrst;
logic        hsel;
logic [31:0] haddr;
logic [1:0]  htrans;
logic        hwrite;
logic [31:0] hwdata;
logic [31:0] hrdata;
logic        hreadyout;
logic        hresp;
logic        irq;
logic        rc_osc;
logic        cmp_above;
logic [11:0] dac_code;
logic        sample;
logic        busy;
logic [11:0] vin;
logic        rc_run;
logic [3:0]  rc_cnt;
int          cyc;
int          n_fail;
int          num_checks;
row_s        rows [15];

adc_control_top i_adc_control_top (
	.I_CLK       (clk),
	.I_NRST      (nrst),
	.I_HSEL      (hsel),
	.I_HADDR     (haddr),
	.I_HTRANS    (htrans),
	.I_HWRITE    (hwrite),
	.I_HSIZE     (3'h2),
	.I_HWDATA    (hwdata),
	.I_HREADY    (hreadyout),
	.O_HRDATA    (hrdata),
	.O_HREADYOUT (hreadyout),
	.O_HRESP     (hresp),
	.O_IRQ       (irq),
	.I_RC_OSC    (rc_osc),
	.I_CMP_ABOVE (cmp_above),
	.O_DAC_CODE  (dac_code),
	.O_SAMPLE    (sample),
	.O_BUSY      (busy)
);

////////////////////////////////////////////////////////////////////////////////
initial clk = 1'b0;
always #25 clk = ~clk;

// ideal comparator against the bench input level
always @(posedge clk) cmp_above <= (vin >= dac_code);

// rc oscillator runs only when asked, period 16 system clocks
always @(posedge clk) begin
	rc_cnt <= rc_run ? rc_cnt + 4'h1 : 4'h0;
	rc_osc <= rc_run ? rc_cnt[3] : 1'b0;
end

always @(posedge clk) begin
	cyc <= cyc + 1;
	if (cyc == 5000) begin
		n_fail++;
		test_done();
	end
end

////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] expv);
	num_checks++;
	if (got !== expv) begin
		n_fail++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, expv);
	end
endtask

task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
	hsel   <= 1'b1;
	haddr  <= a;
	htrans <= 2'h2;
	hwrite <= w;
	do @(posedge clk); while (hreadyout !== 1'b1);
	htrans <= 2'h0;
	hwdata <= wd;
	do @(posedge clk); while (hreadyout !== 1'b1);
	rd = hrdata;
endtask

task automatic wr(input logic [31:0] a, input logic [31:0] d);
	logic [31:0] rd;
	xfer(a, 1'b1, d, rd);
endtask

task automatic rdc(input logic [31:0] a, input logic [31:0] expv);
	logic [31:0] rd;
	xfer(a, 1'b0, 32'h0, rd);
	chk(rd, expv);
endtask

task automatic wait_idle();
	repeat (2) @(posedge clk);
	do @(posedge clk); while (busy !== 1'b0);
endtask

task automatic test_done();
	$display("checks %0d failures %0d", num_checks, n_fail);
	if (n_fail == 0 && num_checks > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
	{nrst, hsel, haddr, htrans, hwrite, hwdata} = '0;
	{cmp_above, rc_osc, rc_run, rc_cnt, cyc, n_fail, num_checks} = '0;
	vin = 12'h5a3;
	rows = '{
		'{1'b0, 32'h00, 32'h0, 32'h0},   '{1'b0, 32'h04, 32'h0, 32'h0},
		'{1'b0, 32'h08, 32'h0, 32'h0},   '{1'b0, 32'h14, 32'h0, 32'hfff},
		'{1'b0, 32'h18, 32'h0, 32'h0},   '{1'b0, 32'h1c, 32'h0, 32'h0},
		'{1'b1, 32'h00, 32'h3e, 32'h14}, '{1'b1, 32'h00, 32'h2b, 32'h0},
		'{1'b1, 32'h04, 32'h5a, 32'h5a}, '{1'b1, 32'h04, 32'h0, 32'h0},
		'{1'b1, 32'h14, 32'h123, 32'h123}, '{1'b1, 32'h14, 32'hfff, 32'hfff},
		'{1'b1, 32'h10, 32'h1, 32'h1},   '{1'b1, 32'h10, 32'h0, 32'h0},
		'{1'b1, 32'h100, 32'h55, 32'h0}
	};
	repeat (10) @(posedge clk);
	nrst <= 1'b1;
	@(posedge clk);
	foreach (rows[i]) begin
		if (rows[i].wr)
			wr(rows[i].addr, rows[i].data);
		rdc(rows[i].addr, rows[i].expv);
	end
	wr(32'h00, 32'h05);
	repeat (4) @(posedge clk);
	chk(busy, 1'b0);
	rdc(32'h00, 32'h04);
	// single conversion, right justified, interrupt enabled
	wr(32'h1c, 32'h1);
	wr(32'h00, 32'h85);
	repeat (3) @(posedge clk);
	chk(busy, 1'b1);
	chk(sample, 1'b1);
	rdc(32'h00, 32'h85);
	chk(hresp, 1'b0);
	wait_idle();
	rdc(32'h00, 32'h84);
	rdc(32'h08, 32'h5a3);
	rdc(32'h18, 32'h1);
	chk(irq, 1'b1);
	wr(32'h1c, 32'h0);
	repeat (2) @(posedge clk);
	chk(irq, 1'b0);
	wr(32'h1c, 32'h1);
	wr(32'h18, 32'h1);
	@(posedge clk);
	chk(irq, 1'b0);
	rdc(32'h18, 32'h0);
	// left justified, previous result follows the format
	vin <= 12'h3c7;
	wr(32'h00, 32'h81);
	wait_idle();
	rdc(32'h08, 32'h3c70);
	rdc(32'h0c, 32'h5a30);
	// abort while still acquiring
	wr(32'h18, 32'h3);
	wr(32'h04, 32'hff);
	wr(32'h00, 32'h85);
	wr(32'h00, 32'h84);
	repeat (3) @(posedge clk);
	chk(busy, 1'b0);
	rdc(32'h08, 32'h0);
	rdc(32'h18, 32'h0);
	chk(irq, 1'b0);
	wr(32'h04, 32'h0);
	// rc clock: stalls until the oscillator runs
	wr(32'h00, 32'h95);
	repeat (100) @(posedge clk);
	chk(busy, 1'b1);
	rc_run <= 1'b1;
	wait_idle();
	rc_run <= 1'b0;
	rdc(32'h08, 32'h3c7);
	// continuous re-arm, then software clear
	wr(32'h00, 32'hc5);
	wait_idle();
	repeat (3) @(posedge clk);
	chk(busy, 1'b1);
	rdc(32'h00, 32'hc5);
	wr(32'h00, 32'hc4);
	repeat (2) @(posedge clk);
	chk(busy, 1'b0);
	rdc(32'h00, 32'hc4);
	// continuous stopped by the threshold flag
	wr(32'h18, 32'h3);
	wr(32'h14, 32'h100);
	wr(32'h10, 32'h1);
	wr(32'h00, 32'hc5);
	wait_idle();
	repeat (3) @(posedge clk);
	chk(busy, 1'b0);
	rdc(32'h00, 32'hc4);
	rdc(32'h18, 32'h3);
	test_done();
end

endmodule
